// ---- hw/frs_cmd_exec.sv ----
`include "frs_params.svh"

module frs_cmd_exec
  import frs_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Command control
  input  wire logic cx_start,
  output      logic cx_busy,
  output      logic cx_done
);

  localparam int CMD_WAIT = `FRS_CMD_CYCLES + 1;

  frs_cx_s_t s_r;
  frs_cx_s_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      CX_IDLE:
      begin
        if (cx_start)
        begin
          s_nxt.st  = CX_RUN;
          s_nxt.cnt = 8'h00;
        end
      end
      CX_RUN:
      begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt == 8'(`FRS_CMD_CYCLES - 1))
        begin
          s_nxt.st   = CX_IDLE;
          s_nxt.done = 1'b1;
        end
      end
      default:
        s_nxt.st = CX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{st: CX_IDLE, cnt: 8'h00, done: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign cx_busy = (s_r.st == CX_RUN);
  assign cx_done = s_r.done;

  // ========================================================================
  // Checks
  cmd_runtime_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cx_start && !cx_busy) |-> ##[1:CMD_WAIT] cx_done)
    else $error("command did not finish in time");

endmodule // frs_cmd_exec

// ---- hw/frs_init_seq.sv ----
`include "frs_params.svh"

module frs_init_seq
  import frs_pkg::*;
(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Nonvolatile array read port
  output      logic        nv_rd,
  output      logic [9:0]  nv_addr,
  input  wire logic [15:0] nv_rdata,
  input  wire logic        nv_rvalid,
  input  wire logic        nv_err,
  input  wire logic        nv_dbl,
  // Status
  output      logic        init_done
);

  frs_top_s_t s_r;
  frs_top_s_t s_nxt;

  logic        ld_req;
  logic [9:0]  ld_addr;
  logic        ld_valid;
  logic [2:0]  ld_item;
  logic        ld_hold;
  logic        ld_done;
  logic        ld_err_seen;
  logic        ld_dbl_seen;
  logic        cx_start;
  logic        cx_busy;
  logic        cx_done;
  logic [4:0]  nv_hit;
  logic        hit_status;
  logic        hit_cmd;
  logic        hit_array;
  logic        acc;
  logic [7:0]  status_byte;

  // ========================================================================
  // Decode
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_nv_hit
      assign nv_hit[gi] = (paddr == 12'((`FRS_IDX_NV0 + gi) * 4));
    end
  endgenerate

  assign hit_status  = (paddr == 12'(`FRS_IDX_STATUS * 4));
  assign hit_cmd     = (paddr == 12'(`FRS_IDX_CMD * 4));
  assign hit_array   = paddr[`FRS_ARRAY_BIT];
  assign acc         = psel && penable;
  assign ld_valid    = nv_rvalid && s_r.nv_busy && !s_r.nv_own_cpu;
  assign status_byte = {s_r.command_complete_flag, 1'b0, s_r.access_error_flag,
                        s_r.protection_violation_flag, cx_busy, 1'b0, s_r.fault};

  // ========================================================================
  // Submodules
  frs_nv_loader i_frs_nv_loader (
    .pclk        (pclk),
    .presetn     (presetn),
    .ld_req      (ld_req),
    .ld_addr     (ld_addr),
    .ld_valid    (ld_valid),
    .ld_err      (nv_err),
    .ld_dbl      (nv_dbl),
    .ld_item     (ld_item),
    .ld_hold     (ld_hold),
    .ld_done     (ld_done),
    .ld_err_seen (ld_err_seen),
    .ld_dbl_seen (ld_dbl_seen)
  );

  frs_cmd_exec i_frs_cmd_exec (
    .pclk     (pclk),
    .presetn  (presetn),
    .cx_start (cx_start),
    .cx_busy  (cx_busy),
    .cx_done  (cx_done)
  );

  // ========================================================================
  // Next state
  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.nv_rd = 1'b0;
    cx_start    = 1'b0;

    // Array read returns
    if (nv_rvalid && s_r.nv_busy)
    begin
      s_nxt.nv_busy = 1'b0;
      if (s_r.nv_own_cpu)
      begin
        s_nxt.cpu_pend = 1'b0;
        s_nxt.apb_rdy  = 1'b1;
        s_nxt.prdata   = {16'h0000, nv_rdata};
        s_nxt.slverr   = nv_err | nv_dbl;
      end
      else
      begin
        s_nxt.nvreg[ld_item] = nv_rdata;
      end
    end

    // Loader has priority on the array port
    if (!s_r.nv_busy)
    begin
      if (ld_req)
      begin
        s_nxt.nv_rd      = 1'b1;
        s_nxt.nv_addr    = ld_addr;
        s_nxt.nv_busy    = 1'b1;
        s_nxt.nv_own_cpu = 1'b0;
      end
      else if (s_r.cpu_pend)
      begin
        s_nxt.nv_rd      = 1'b1;
        s_nxt.nv_addr    = {1'b0, paddr[10:2]};
        s_nxt.nv_busy    = 1'b1;
        s_nxt.nv_own_cpu = 1'b1;
      end
    end

    // Bus access
    if (acc && s_r.apb_rdy)
    begin
      s_nxt.apb_rdy = 1'b0;
      s_nxt.slverr  = 1'b0;
      if (pwrite && !s_r.slverr && hit_status)
      begin
        if (pwdata[`FRS_ST_ACCESS_ERR])
          s_nxt.access_error_flag = 1'b0;
        if (pwdata[`FRS_ST_PROT_VIOL])
          s_nxt.protection_violation_flag = 1'b0;
        if (pwdata[`FRS_ST_DONE_FLAG] && s_r.command_complete_flag && s_r.init_done)
        begin
          if (s_r.cmd_code != `FRS_CMD_PROGRAM && s_r.cmd_code != `FRS_CMD_ERASE)
            s_nxt.access_error_flag = 1'b1;
          else if (s_r.nvreg[1] == `FRS_PROT_FULL)
            s_nxt.protection_violation_flag = 1'b1;
          else
          begin
            s_nxt.command_complete_flag = 1'b0;
            cx_start                    = 1'b1;
          end
        end
      end
      if (pwrite && !s_r.slverr && hit_cmd)
        s_nxt.cmd_code = pwdata[7:0];
    end
    else if (acc && !ld_hold && !s_r.cpu_pend && !(s_r.nv_busy && s_r.nv_own_cpu))
    begin
      if (hit_array && !pwrite)
        s_nxt.cpu_pend = 1'b1;
      else
      begin
        s_nxt.apb_rdy = 1'b1;
        s_nxt.slverr  = hit_array || !(hit_status || hit_cmd || (|nv_hit));
        s_nxt.prdata  = 32'h0000_0000;
        if (!pwrite)
        begin
          if (hit_status)
            s_nxt.prdata = {24'h00_0000, status_byte};
          else if (hit_cmd)
            s_nxt.prdata = {24'h00_0000, s_r.cmd_code};
          else
          begin
            for (int i = 0; i < 5; i++)
              if (nv_hit[i])
                s_nxt.prdata = {16'h0000, s_r.nvreg[i]};
          end
        end
      end
    end

    // Command completion sets the flag after any clear
    if (cx_done)
      s_nxt.command_complete_flag = 1'b1;

    if (ld_done && !s_r.init_done)
    begin
      s_nxt.init_done             = 1'b1;
      s_nxt.command_complete_flag = 1'b1;
      // fall back to protected secured defaults
      if (ld_err_seen)
        s_nxt.nvreg = {`FRS_SEC_SECURED, `FRS_DFLT_OPT, `FRS_PROT_FULL,
                       `FRS_PROT_FULL, `FRS_DFLT_CFG};
      if (ld_dbl_seen)
        s_nxt.fault = 2'b11;
    end
  end

  // flag reset low until loader done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign prdata    = s_r.prdata;
  assign pready    = s_r.apb_rdy;
  assign pslverr   = s_r.slverr;
  assign nv_rd     = s_r.nv_rd;
  assign nv_addr   = s_r.nv_addr;
  assign init_done = s_r.init_done;

  // ========================================================================
  // Checks
  load_list_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ld_done ##1 ld_done) |-> ($past(ld_valid) && $past(ld_item) == 3'd4))
    else $error("load list not completed before done");

  dflt_on_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_done && !s_r.init_done && ld_err_seen) |=>
      (s_r.nvreg[4] == `FRS_SEC_SECURED && s_r.nvreg[1] == `FRS_PROT_FULL
       && s_r.nvreg[2] == `FRS_PROT_FULL))
    else $error("defaults not applied after load error");

  dbl_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_done && !s_r.init_done && ld_dbl_seen) |=> (s_r.fault == 2'b11))
    else $error("double fault not reported");

  done_flag_low_a: assert property (@(posedge pclk) disable iff (!presetn)
    !s_r.init_done |-> !s_r.command_complete_flag)
    else $error("command complete flag high during init");

  hold_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_hold && acc && !s_r.apb_rdy) |=> !s_r.apb_rdy)
    else $error("access answered during hold");

  read_served_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ld_hold && acc && !s_r.apb_rdy && !pwrite && hit_status && !s_r.cpu_pend
     && !s_r.nv_busy) |=> s_r.apb_rdy)
    else $error("register read not served after hold");

  done_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_done && !s_r.init_done) |=> (s_r.command_complete_flag && s_r.init_done))
    else $error("command complete not set at end of init");

  status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!ld_hold && acc && !s_r.apb_rdy && !pwrite && hit_status && !s_r.cpu_pend
     && !s_r.nv_busy) |=> (s_r.prdata[7:0] == $past(status_byte)))
    else $error("status read data wrong");

  fault_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && s_r.apb_rdy && pwrite && hit_status && s_r.init_done) |=> $stable(s_r.fault))
    else $error("fault status changed by a write");

  held_no_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_hold |-> (!s_r.apb_rdy && !pslverr))
    else $error("held access returned a response");

  pend_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.cpu_pend |-> !s_r.apb_rdy)
    else $error("array read answered while still pending");

  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && s_r.apb_rdy) |=> !s_r.apb_rdy)
    else $error("ready held for more than one cycle");

  launch_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    cx_start |-> (s_r.init_done && s_r.command_complete_flag))
    else $error("command launched before init done");

  init_ok_c: cover property (@(posedge pclk) disable iff (!presetn)
    (ld_done && !s_r.init_done && !ld_err_seen));
  init_err_c: cover property (@(posedge pclk) disable iff (!presetn)
    (ld_done && !s_r.init_done && ld_dbl_seen));
  early_read_c: cover property (@(posedge pclk) disable iff (!presetn)
    (!ld_hold && !ld_done && s_r.apb_rdy && !pwrite));
  launch_c: cover property (@(posedge pclk) disable iff (!presetn) cx_start);

endmodule // frs_init_seq

// ---- hw/frs_nv_loader.sv ----
`include "frs_params.svh"

module frs_nv_loader
  import frs_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Read path to the nonvolatile array
  output      logic       ld_req,
  output      logic [9:0] ld_addr,
  input  wire logic       ld_valid,
  input  wire logic       ld_err,
  input  wire logic       ld_dbl,
  // Progress
  output      logic [2:0] ld_item,
  output      logic       ld_hold,
  output      logic       ld_done,
  output      logic       ld_err_seen,
  output      logic       ld_dbl_seen
);

  frs_ld_s_t s_r;
  frs_ld_s_t s_nxt;

  // ========================================================================
  // Walk the load list once per reset
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      LD_READ:
      begin
        if (ld_valid)
        begin
          s_nxt.err = s_r.err | ld_err | ld_dbl;
          s_nxt.dbl = s_r.dbl | ld_dbl;
          if (s_r.item == `FRS_HOLD_LAST)
            s_nxt.hold = 1'b0;
          if (s_r.item == `FRS_NV_LAST)
            s_nxt.st = LD_DONE;
          else
            s_nxt.item = s_r.item + 3'd1;
        end
      end
      LD_DONE:
        s_nxt.st = LD_DONE;
      default:
        s_nxt.st = LD_DONE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_r <= '{st: LD_READ, item: 3'd0, hold: 1'b1, err: 1'b0, dbl: 1'b0};
    else
      s_r <= s_nxt;
  end

  assign ld_req      = (s_r.st == LD_READ);
  assign ld_addr     = `FRS_NV_CFG_ADDR + {7'h00, s_r.item};
  assign ld_item     = s_r.item;
  assign ld_hold     = s_r.hold;
  assign ld_done     = (s_r.st == LD_DONE);
  assign ld_err_seen = s_r.err;
  assign ld_dbl_seen = s_r.dbl;

endmodule // frs_nv_loader

// ---- hw/frs_params.svh ----
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH

// ==========================================================================
// Register indices (byte address is four times the index) and the array select address bit
`define FRS_IDX_STATUS     6
`define FRS_IDX_NV0        8
`define FRS_IDX_CMD        13
`define FRS_ARRAY_BIT      11

// ==========================================================================
// Status register fields
`define FRS_ST_DONE_FLAG   7
`define FRS_ST_ACCESS_ERR  5
`define FRS_ST_PROT_VIOL   4
`define FRS_ST_BUSY        3
`define FRS_ST_FAULT_HI    1
`define FRS_ST_FAULT_LO    0

// ==========================================================================
// Nonvolatile load list: 0 config, 1 program prot, 2 data prot, 3 option, 4 security
`define FRS_NV_LAST        3'd4
`define FRS_HOLD_LAST      3'd2
`define FRS_NV_CFG_ADDR    10'h3F8

// ==========================================================================
// Built-in defaults: fully protected, secured
`define FRS_DFLT_CFG       16'h0000
`define FRS_PROT_FULL      16'h0000
`define FRS_DFLT_OPT       16'hFFFF
`define FRS_SEC_SECURED    16'hFFFE

// ==========================================================================
// Commands and timing
`define FRS_CMD_PROGRAM    8'h06
`define FRS_CMD_ERASE      8'h0A
`define FRS_CLK_PERIOD_NS  5
`define FRS_CMD_TIME_NS    1000
`define FRS_CMD_CYCLES     ((`FRS_CMD_TIME_NS + `FRS_CLK_PERIOD_NS - 1) / `FRS_CLK_PERIOD_NS)

`endif

// ---- hw/frs_pkg.sv ----
package frs_pkg;

  // ========================================================================
  // State encodings
  typedef enum logic [1:0] {
    LD_READ = 2'b01,
    LD_DONE = 2'b10
  } frs_ld_state_t;

  typedef enum logic [1:0] {
    CX_IDLE = 2'b01,
    CX_RUN  = 2'b10
  } frs_cx_state_t;

  // ========================================================================
  // Module state records
  typedef struct packed {
    frs_ld_state_t st;
    logic [2:0]    item;
    logic          hold;
    logic          err;
    logic          dbl;
  } frs_ld_s_t;

  typedef struct packed {
    frs_cx_state_t st;
    logic [7:0]    cnt;
    logic          done;
  } frs_cx_s_t;

  typedef struct packed {
    logic             apb_rdy;
    logic [31:0]      prdata;
    logic             slverr;
    logic             cpu_pend;
    logic             command_complete_flag;
    logic             access_error_flag;
    logic             protection_violation_flag;
    logic [1:0]       fault;
    logic [4:0][15:0] nvreg;
    logic [7:0]       cmd_code;
    logic             nv_rd;
    logic [9:0]       nv_addr;
    logic             nv_busy;
    logic             nv_own_cpu;
    logic             init_done;
  } frs_top_s_t;

endpackage

// ---- test/frs_nv_model.sv ----
// ==========================================
// Nonvolatile array: answers one read at a time
module frs_nv_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Read port
  input  wire logic        nv_rd,
  input  wire logic [9:0]  nv_addr,
  output      logic [15:0] nv_rdata,
  output      logic        nv_rvalid,
  output      logic        nv_err,
  output      logic        nv_dbl,
  // Scenario control
  input  wire logic [7:0]  lat,
  input  wire logic [2:0]  bad_item,
  input  wire logic [1:0]  bad_kind
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       busy;
  logic [7:0] cnt;
  logic [9:0] addr;
  logic [3:0] n;
  logic       hit;

  assign hit = (n == {1'b0, bad_item});

  // Data lines toggle whenever no answer is valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy      <= 1'b0;
      n         <= 4'h0;
      nv_rvalid <= 1'b0;
      nv_err    <= 1'b0;
      nv_dbl    <= 1'b0;
      nv_rdata  <= 16'h5A5A;
    end
    else
    begin
      nv_rvalid <= 1'b0;
      nv_err    <= 1'b0;
      nv_dbl    <= 1'b0;
      nv_rdata  <= ~nv_rdata;
      if (nv_rd)
      begin
        busy <= 1'b1;
        cnt  <= lat;
        addr <= nv_addr;
      end
      else if (busy && cnt != 8'h00)
        cnt <= cnt - 8'h01;
      else if (busy)
      begin
        busy      <= 1'b0;
        nv_rvalid <= 1'b1;
        nv_rdata  <= {6'h2A, addr};
        nv_err    <= hit & bad_kind[0];
        nv_dbl    <= hit & bad_kind[1];
        n         <= n + 4'h1;
      end
    end
  end
endmodule // frs_nv_model

// ---- test/test_frs_init_seq.sv ----
`include "frs_params.svh"

module test_frs_init_seq;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] ST  = 12'h018;
  localparam logic [11:0] CMD = 12'h034;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        nv_rd;
  logic [9:0]  nv_addr;
  logic [15:0] nv_rdata;
  logic        nv_rvalid;
  logic        nv_err;
  logic        nv_dbl;
  logic        init_done;
  logic [7:0]  lat;
  logic [2:0]  bad_item;
  logic [1:0]  bad_kind;
  logic [7:0]  code;
  logic [33:0] exp_q[$];
  logic [15:0] dflt[5];
  int          n_errors;
  int          n_compared;
  int          n_ans;
  int          seed;

  frs_init_seq i_frs_init_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .nv_rd, .nv_addr, .nv_rdata, .nv_rvalid, .nv_err, .nv_dbl,
    .init_done);

  frs_nv_model i_frs_nv_model (.pclk, .presetn, .nv_rd, .nv_addr, .nv_rdata, .nv_rvalid,
    .nv_err, .nv_dbl, .lat, .bad_item, .bad_kind);

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk or negedge presetn)
    if (!presetn)
      n_ans <= 0;
    else if (nv_rvalid === 1'b1)
      n_ans <= n_ans + 1;

  // ==========================================
  // Result watcher
  always @(posedge pclk)
    if (pready === 1'b1)
      chk_ans(exp_q.size() > 0 ? exp_q.pop_front() : 34'h3FFFFFFFF);

  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_flag(input logic e, input logic g);
    cmp({32'h0, e}, {32'h0, g});
  endtask

  task automatic chk_ans(input logic [33:0] e);
    cmp(e[32:0], {pslverr, e[33] ? prdata : e[31:0]});
  endtask

  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Bus master
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int i;
    exp_q.push_back({~w, e});
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 3000; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (i == 3000)
    begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic do_reset;
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic wait_init;
    int i;
    for (i = 0; i < 3000 && init_done !== 1'b1; i++)
      @(posedge pclk);
    if (init_done !== 1'b1)
    begin
      n_errors++;
      complete_run();
    end
  endtask

  task automatic chk_regs(input logic dfl);
    int i;
    for (i = 0; i < 5; i++)
      rd(12'h020 + 12'(4 * i), dfl ? {16'h0, dflt[i]} : 32'h0000ABF8 + 32'(i));
  endtask

  task automatic launch(input logic [7:0] c);
    wr(CMD, {24'h0, c});
    wr(ST, 32'h80);
  endtask

  // ==========================================
  // Main sequence
  initial
  begin
    int k;
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    lat      = 8'h28;
    bad_item = 3'h0;
    bad_kind = 2'h0;
    seed     = 69;
    dflt = '{`FRS_DFLT_CFG, `FRS_PROT_FULL, `FRS_PROT_FULL, `FRS_DFLT_OPT, `FRS_SEC_SECURED};
    do_reset();
    rd(ST, 32'h00);
    cmp_flag(1'b1, n_ans >= 3);
    cmp_flag(1'b0, init_done);
    rd(12'h810, 32'h0000A804);
    wait_init();
    rd(ST, 32'h80);
    chk_regs(1'b0);
    $display("test clean load done");
    apb(1'b1, 12'h038, 32'h0, {1'b1, 32'h0});
    code = 8'($random(seed));
    if (code == 8'h06 || code == 8'h0A)
      code = code ^ 8'h01;
    launch(code);
    rd(ST, 32'hA0);
    wr(ST, 32'h20);
    rd(ST, 32'h80);
    launch(8'h06);
    rd(ST, 32'h08);
    repeat (205) @(posedge pclk);
    rd(ST, 32'h80);
    launch(8'h0A);
    rd(ST, 32'h08);
    do_reset();
    rd(ST, 32'h00);
    wait_init();
    $display("test commands done");
    for (k = 1; k < 3; k++)
    begin
      bad_kind <= 2'(k);
      bad_item <= 3'(k + 1);
      lat      <= 8'($random(seed)) & 8'h07;
      do_reset();
      wait_init();
      rd(ST, k == 2 ? 32'h83 : 32'h80);
      chk_regs(1'b1);
    end
    wr(ST, 32'h03);
    rd(ST, 32'h83);
    launch(8'h06);
    rd(ST, 32'h93);
    $display("test fault load done");
    complete_run();
  end
endmodule // test_frs_init_seq
